// File: xpr_params.svh
// Purpose: Named constants for the flash recovery sequencer.
// Assumes: 250 MHz system clock, single-rate serial clock made by division.
// Notes: Times other than the reset pulse are given in their own unit and converted to cycles here.
`ifndef XPR_PARAMS_SVH
`define XPR_PARAMS_SVH

// ==========================================================================
// Timing
`define XPR_CLK_NS 4
`define XPR_SCLK_NS 48
`define XPR_HALF_CYC (`XPR_SCLK_NS / (2 * `XPR_CLK_NS))
`define XPR_GAP_NS 50
`define XPR_GAP_CYC ((`XPR_GAP_NS + `XPR_CLK_NS - 1) / `XPR_CLK_NS)
`define XPR_READY_US 300
`define XPR_READY_CYC ((`XPR_READY_US * 1000 + `XPR_CLK_NS - 1) / `XPR_CLK_NS)
`define XPR_WI_WAIT_US 100
`define XPR_WI_WAIT_CYC ((`XPR_WI_WAIT_US * 1000 + `XPR_CLK_NS - 1) / `XPR_CLK_NS)
`define XPR_RST_PULSE_CYC 16

// ==========================================================================
// Frame lengths in serial clocks
`define XPR_LEN0 6'h07
`define XPR_LEN1 6'h09
`define XPR_LEN2 6'h0D
`define XPR_LEN3 6'h11
`define XPR_LEN4 6'h19
`define XPR_LEN5 6'h21
`define XPR_SERIES_LAST 3'h5
`define XPR_LEN_RECOVER2 6'h08
`define XPR_LEN_RESCUE2 6'h10
`define XPR_LEN_CMD 6'h08
`define XPR_LEN_POLL 6'h10

// ==========================================================================
// Fields and pin levels
`define XPR_FLAG_READY_BIT 7
`define XPR_OE_N_IDLE 4'hF
`define XPR_OE_N_FRAME 4'h6
`define XPR_DQ_FRAME 4'h8

`endif

// File: xpr_pkg.sv
// Purpose: Types shared by the flash recovery sequencer modules.
// Assumes: Nothing beyond SystemVerilog packed types.
// Notes: Constants live in xpr_params.svh.
package xpr_pkg;

  // ========================================================================
  // Requests and states
  typedef enum logic [2:0] {
    OP_TERMINATE = 3'b000,
    OP_RECOVER = 3'b001,
    OP_RESCUE = 3'b010,
    OP_HW_RESET = 3'b011,
    OP_POLL = 3'b100
  } xpr_op_t;

  typedef enum logic [3:0] {
    S_PWR_WAIT = 4'b0000,
    S_PWR_POLL = 4'b0001,
    S_IDLE = 4'b0010,
    S_SERIES = 4'b0011,
    S_STEP2 = 4'b0100,
    S_RST_ARM = 4'b0101,
    S_RST_MEM = 4'b0110,
    S_POLL = 4'b0111,
    S_HWRST = 4'b1000
  } xpr_state_t;

  typedef enum logic [2:0] {
    F_IDLE = 3'b000,
    F_LOW = 3'b001,
    F_HIGH = 3'b010,
    F_TAIL = 3'b011,
    F_GAP = 3'b100
  } xpr_fstate_t;

  // ========================================================================
  // Carriers
  typedef struct packed {
    logic [5:0] len;
    logic tx_en;
    logic [7:0] tx;
  } xpr_frame_t;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic reset_n;
    logic [3:0] dq;
    logic [3:0] dq_oe_n;
  } xpr_pins_t;

endpackage

// File: xpr_frame_gen.sv
// Purpose: One chip-select frame of a given number of serial clocks.
// Assumes: Mode 0 clocking; miso_i is already synchronised.
// Notes: Ends each frame with a deselect gap before reporting done.
`timescale 1ns/1ps
`include "xpr_params.svh"

module xpr_frame_gen #(
  parameter int unsigned HALF_CYC = `XPR_HALF_CYC,
  parameter int unsigned GAP_CYC = `XPR_GAP_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Frame request
  input wire logic start_i,
  input wire xpr_pkg::xpr_frame_t req_i,
  input wire logic miso_i,
  // Frame outputs
  output logic sclk_o,
  output logic cs_n_o,
  output logic dq0_o,
  output logic done_o,
  output logic [7:0] rx_o
);

  // ========================================================================
  // Frame engine
  xpr_pkg::xpr_fstate_t fstate;
  logic [7:0] div_cnt;
  logic [5:0] bit_cnt;
  logic [5:0] len_reg;
  logic [7:0] tx_reg;
  logic div_end;
  logic gap_end;

  assign div_end = (div_cnt == 8'(HALF_CYC - 1));
  assign gap_end = (div_cnt == 8'(GAP_CYC - 1));

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fstate <= xpr_pkg::F_IDLE;
      div_cnt <= 8'h00;
      bit_cnt <= 6'h00;
      len_reg <= 6'h00;
      tx_reg <= 8'hFF;
      rx_o <= 8'h00;
      sclk_o <= 1'b0;
      cs_n_o <= 1'b1;
      dq0_o <= 1'b1;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      unique case (fstate)
        xpr_pkg::F_IDLE: begin
          if (start_i) begin
            len_reg <= req_i.len;
            tx_reg <= req_i.tx_en ? {req_i.tx[6:0], 1'b1} : 8'hFF;
            dq0_o <= req_i.tx_en ? req_i.tx[7] : 1'b1;
            cs_n_o <= 1'b0;
            div_cnt <= 8'h00;
            bit_cnt <= 6'h00;
            fstate <= xpr_pkg::F_LOW;
          end
        end
        xpr_pkg::F_LOW: begin
          div_cnt <= div_end ? 8'h00 : div_cnt + 8'h01;
          if (div_end) begin
            sclk_o <= 1'b1;
            fstate <= xpr_pkg::F_HIGH;
          end
        end
        xpr_pkg::F_HIGH: begin
          div_cnt <= div_end ? 8'h00 : div_cnt + 8'h01;
          if (div_end) begin
            sclk_o <= 1'b0;
            rx_o <= {rx_o[6:0], miso_i};
            bit_cnt <= bit_cnt + 6'h01;
            if (bit_cnt == len_reg - 6'h01) begin
              fstate <= xpr_pkg::F_TAIL;
            end else begin
              dq0_o <= tx_reg[7];
              tx_reg <= {tx_reg[6:0], 1'b1};
              fstate <= xpr_pkg::F_LOW;
            end
          end
        end
        xpr_pkg::F_TAIL: begin
          div_cnt <= div_end ? 8'h00 : div_cnt + 8'h01;
          if (div_end) begin
            cs_n_o <= 1'b1;
            dq0_o <= 1'b1;
            fstate <= xpr_pkg::F_GAP;
          end
        end
        xpr_pkg::F_GAP: begin
          div_cnt <= gap_end ? 8'h00 : div_cnt + 8'h01;
          if (gap_end) begin
            done_o <= 1'b1;
            fstate <= xpr_pkg::F_IDLE;
          end
        end
        default: begin
          fstate <= xpr_pkg::F_IDLE;
        end
      endcase
    end
  end

  // ========================================================================
  // Checks
  logic [5:0] edge_cnt;
  logic sclk_q;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      edge_cnt <= 6'h00;
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk_o;
      if ($fell(cs_n_o)) begin
        edge_cnt <= 6'h00;
      end else if (sclk_o && !sclk_q) begin
        edge_cnt <= edge_cnt + 6'h01;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  a_frame_clock_count: assert property ($rose(cs_n_o) |-> edge_cnt == len_reg)
    else $error("Frame clock count differs from request.");
  a_sclk_low_deselect: assert property (cs_n_o |-> !sclk_o)
    else $error("Serial clock high while deselected.");
  a_gap_then_done: assert property ($rose(cs_n_o) |-> !done_o [*8] ##[1:20] done_o)
    else $error("Done not reported after the deselect gap.");

endmodule

// File: xpr_seq.sv
// Purpose: Host sequencer for flash power-up, termination, recovery and rescue.
// Assumes: Supply monitor levels arrive asynchronously and are synchronised.
// Notes: Single-rate serial clock only; double-rate rescue is not generated.
`timescale 1ns/1ps
`include "xpr_params.svh"

module xpr_seq #(
  parameter int unsigned READY_CYC = `XPR_READY_CYC,
  parameter int unsigned WI_WAIT_CYC = `XPR_WI_WAIT_CYC,
  parameter int unsigned RST_PULSE_CYC = `XPR_RST_PULSE_CYC,
  parameter logic [7:0] CMD_RST_ARM = 8'h66,
  parameter logic [7:0] CMD_RST_MEM = 8'h99,
  parameter logic [7:0] CMD_RD_FLAG = 8'h70
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Supply monitor
  input wire logic supply_ok_i,
  input wire logic wi_ok_i,
  // Flash pins
  input wire logic flash_dq1_i,
  output xpr_pkg::xpr_pins_t pins_o,
  // User side
  input wire logic start_i,
  input wire xpr_pkg::xpr_op_t op_i,
  output logic busy_o,
  output logic done_o,
  output logic ready_o,
  output logic [7:0] status_o
);

  // ========================================================================
  // Synchronisers
  logic supply_meta, supply_s, wi_meta, wi_s, dq1_meta, dq1_s;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      {supply_meta, supply_s, wi_meta, wi_s, dq1_meta, dq1_s} <= 6'h00;
    end else begin
      supply_meta <= supply_ok_i;
      supply_s <= supply_meta;
      wi_meta <= wi_ok_i;
      wi_s <= wi_meta;
      dq1_meta <= flash_dq1_i;
      dq1_s <= dq1_meta;
    end
  end

  // ========================================================================
  // Frame engine
  xpr_pkg::xpr_frame_t f_req;
  logic f_start, f_sclk, f_cs_n, f_dq0, f_done;
  logic [7:0] f_rx;

  xpr_frame_gen u_frame (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .start_i(f_start),
    .req_i(f_req),
    .miso_i(dq1_s),
    .sclk_o(f_sclk),
    .cs_n_o(f_cs_n),
    .dq0_o(f_dq0),
    .done_o(f_done),
    .rx_o(f_rx)
  );

  function automatic logic [5:0] series_len(input logic [2:0] idx);
    unique case (idx)
      3'h0: series_len = `XPR_LEN0;
      3'h1: series_len = `XPR_LEN1;
      3'h2: series_len = `XPR_LEN2;
      3'h3: series_len = `XPR_LEN3;
      3'h4: series_len = `XPR_LEN4;
      default: series_len = `XPR_LEN5;
    endcase
  endfunction

  function automatic xpr_pkg::xpr_frame_t mk(input logic [5:0] len, input logic en,
                                             input logic [7:0] tx);
    mk = '{len: len, tx_en: en, tx: tx};
  endfunction

  // ========================================================================
  // Sequencer
  xpr_pkg::xpr_state_t state;
  xpr_pkg::xpr_op_t op_reg;
  logic [2:0] idx;
  logic [23:0] wait_cnt;
  logic rst_n_reg;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= xpr_pkg::S_PWR_WAIT;
      op_reg <= xpr_pkg::OP_POLL;
      idx <= 3'h0;
      wait_cnt <= 24'h000000;
      f_start <= 1'b0;
      f_req <= '0;
      rst_n_reg <= 1'b1;
      busy_o <= 1'b1;
      done_o <= 1'b0;
      ready_o <= 1'b0;
      status_o <= 8'h00;
    end else begin
      f_start <= 1'b0;
      done_o <= 1'b0;
      unique case (state)
        xpr_pkg::S_PWR_WAIT: begin
          busy_o <= 1'b1;
          ready_o <= 1'b0;
          if (!supply_s || !wi_s) begin
            wait_cnt <= 24'h000000;
          end else if (wait_cnt >= 24'(WI_WAIT_CYC - 1)) begin
            wait_cnt <= 24'h000000;
            f_start <= 1'b1;
            f_req <= mk(`XPR_LEN_POLL, 1'b1, CMD_RD_FLAG);
            state <= xpr_pkg::S_PWR_POLL;
          end else begin
            wait_cnt <= wait_cnt + 24'h000001;
          end
        end
        xpr_pkg::S_PWR_POLL: begin
          if (wait_cnt < 24'(READY_CYC)) begin
            wait_cnt <= wait_cnt + 24'h000001;
          end
          if (f_done) begin
            status_o <= f_rx;
            if (!supply_s) begin
              state <= xpr_pkg::S_PWR_WAIT;
            end else if (f_rx[`XPR_FLAG_READY_BIT] || wait_cnt >= 24'(READY_CYC)) begin
              ready_o <= 1'b1;
              busy_o <= 1'b0;
              state <= xpr_pkg::S_IDLE;
            end else begin
              f_start <= 1'b1;
            end
          end
        end
        xpr_pkg::S_IDLE: begin
          if (!supply_s) begin
            state <= xpr_pkg::S_PWR_WAIT;
          end else if (start_i) begin
            op_reg <= op_i;
            busy_o <= 1'b1;
            unique case (op_i)
              xpr_pkg::OP_TERMINATE, xpr_pkg::OP_RECOVER, xpr_pkg::OP_RESCUE: begin
                idx <= 3'h0;
                f_start <= 1'b1;
                f_req <= mk(series_len(3'h0), 1'b0, 8'hFF);
                state <= xpr_pkg::S_SERIES;
              end
              xpr_pkg::OP_HW_RESET: begin
                rst_n_reg <= 1'b0;
                wait_cnt <= 24'h000000;
                state <= xpr_pkg::S_HWRST;
              end
              xpr_pkg::OP_POLL: begin
                f_start <= 1'b1;
                f_req <= mk(`XPR_LEN_POLL, 1'b1, CMD_RD_FLAG);
                state <= xpr_pkg::S_POLL;
              end
              default: begin
                busy_o <= 1'b0;
                done_o <= 1'b1;
              end
            endcase
          end
        end
        xpr_pkg::S_SERIES: begin
          if (f_done) begin
            f_start <= 1'b1;
            if (idx != `XPR_SERIES_LAST) begin
              idx <= idx + 3'h1;
              f_req <= mk(series_len(idx + 3'h1), 1'b0, 8'hFF);
            end else if (op_reg == xpr_pkg::OP_TERMINATE) begin
              f_req <= mk(`XPR_LEN_CMD, 1'b1, CMD_RST_ARM);
              state <= xpr_pkg::S_RST_ARM;
            end else if (op_reg == xpr_pkg::OP_RECOVER) begin
              f_req <= mk(`XPR_LEN_RECOVER2, 1'b0, 8'hFF);
              state <= xpr_pkg::S_STEP2;
            end else begin
              f_req <= mk(`XPR_LEN_RESCUE2, 1'b0, 8'hFF);
              state <= xpr_pkg::S_STEP2;
            end
          end
        end
        xpr_pkg::S_RST_ARM: begin
          if (f_done) begin
            f_start <= 1'b1;
            f_req <= mk(`XPR_LEN_CMD, 1'b1, CMD_RST_MEM);
            state <= xpr_pkg::S_RST_MEM;
          end
        end
        xpr_pkg::S_STEP2, xpr_pkg::S_RST_MEM: begin
          if (f_done) begin
            busy_o <= 1'b0;
            done_o <= 1'b1;
            state <= xpr_pkg::S_IDLE;
          end
        end
        xpr_pkg::S_POLL: begin
          if (f_done) begin
            status_o <= f_rx;
            if (f_rx[`XPR_FLAG_READY_BIT]) begin
              busy_o <= 1'b0;
              done_o <= 1'b1;
              state <= xpr_pkg::S_IDLE;
            end else begin
              f_start <= 1'b1;
            end
          end
        end
        xpr_pkg::S_HWRST: begin
          wait_cnt <= wait_cnt + 24'h000001;
          if (wait_cnt >= 24'(RST_PULSE_CYC - 1)) begin
            rst_n_reg <= 1'b1;
            busy_o <= 1'b0;
            done_o <= 1'b1;
            state <= xpr_pkg::S_IDLE;
          end
        end
        default: begin
          state <= xpr_pkg::S_PWR_WAIT;
        end
      endcase
    end
  end

  // ========================================================================
  // Pin register
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pins_o <= '{sclk: 1'b0, cs_n: 1'b1, reset_n: 1'b1, dq: 4'h0, dq_oe_n: `XPR_OE_N_IDLE};
    end else begin
      pins_o.sclk <= f_sclk;
      pins_o.cs_n <= f_cs_n;
      pins_o.reset_n <= rst_n_reg;
      pins_o.dq <= `XPR_DQ_FRAME | {3'h0, f_dq0};
      pins_o.dq_oe_n <= f_cs_n ? `XPR_OE_N_IDLE : `XPR_OE_N_FRAME;
    end
  end

  // ========================================================================
  // Checks
  logic [7:0] hi_cnt;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hi_cnt <= 8'h00;
    end else if (!pins_o.cs_n) begin
      hi_cnt <= 8'h00;
    end else if (hi_cnt != 8'hFF) begin
      hi_cnt <= hi_cnt + 8'h01;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_series_end;
    state == xpr_pkg::S_SERIES && f_done && idx == `XPR_SERIES_LAST;
  endsequence

  a_reset_deselected: assert property (!pins_o.reset_n |-> pins_o.cs_n)
    else $error("Hardware reset driven while selected.");
  a_ramp_deselect: assert property (state == xpr_pkg::S_PWR_WAIT |-> pins_o.cs_n)
    else $error("Chip select low during supply wait.");
  a_gap_min: assert property ($fell(pins_o.cs_n) |-> hi_cnt >= 8'(`XPR_GAP_CYC))
    else $error("Deselect gap too short.");
  a_series_lines_high: assert property ((state == xpr_pkg::S_SERIES && !pins_o.cs_n) |->
      pins_o.dq[0] && pins_o.dq[3] && pins_o.dq_oe_n == `XPR_OE_N_FRAME)
    else $error("Data lines 0 and 3 not driven high in frame series.");
  a_step_order: assert property ($rose(state == xpr_pkg::S_STEP2) |->
      $past(state) == xpr_pkg::S_SERIES)
    else $error("Second step entered out of order.");
  a_term_reset_cmds: assert property ((s_series_end ##0 (op_reg == xpr_pkg::OP_TERMINATE)) |=>
      state == xpr_pkg::S_RST_ARM && f_req.tx == CMD_RST_ARM && f_start)
    else $error("Reset-arm command not issued after termination.");
  a_recover_step2: assert property ((s_series_end ##0 (op_reg == xpr_pkg::OP_RECOVER)) |=>
      f_req.len == `XPR_LEN_RECOVER2 && !f_req.tx_en)
    else $error("Recovery second step length wrong.");
  a_rescue_step2: assert property ((s_series_end ##0 (op_reg == xpr_pkg::OP_RESCUE)) |=>
      f_req.len == `XPR_LEN_RESCUE2 && !f_req.tx_en)
    else $error("Rescue second step length wrong.");
  a_poll_finish: assert property ((state == xpr_pkg::S_POLL && f_done &&
      f_rx[`XPR_FLAG_READY_BIT]) |=> done_o && !busy_o && state == xpr_pkg::S_IDLE)
    else $error("Poll did not finish on ready flag.");
  a_poll_single_line: assert property (((state == xpr_pkg::S_POLL ||
      state == xpr_pkg::S_PWR_POLL) && !pins_o.cs_n) |-> pins_o.dq_oe_n[1])
    else $error("Host drives data line 1 while polling.");

endmodule

// File: xpr_flash_model.sv
// Purpose: Behavioural flash partner for the recovery sequencer bench.
// Assumes: Mode 0 serial clock; only the flag-status read is answered.
// Notes: Records every frame so the bench can judge each series.
`timescale 1ns/1ps

module xpr_flash_model #(
  parameter logic [7:0] CMD_RD_FLAG = 8'h70
) (
  // Host pins
  input wire xpr_pkg::xpr_pins_t pins_i,
  input wire logic supply_ok_i,
  input wire logic [7:0] busy_polls_i,
  // Device output
  output logic dq1_o
);
  // ======================================================================
  // Frame capture
  int lens[$];
  logic [7:0] cmds[$];
  logic ones[$];
  int viol = 0;
  int polls = 0;
  int cnt = 0;
  logic [7:0] sh = 8'h00;
  logic allone = 1'b1;
  logic drv = 1'b0;
  logic xip = 1'b1;
  realtime t_up = 0.0;

  initial dq1_o = 1'b0;

  always @(negedge pins_i.cs_n) begin
    cnt = 0;
    sh = 8'h00;
    allone = 1'b1;
    if ($realtime - t_up < 50.0) viol++;
    if (supply_ok_i !== 1'b1) viol++;
  end

  // Upper lines are never read as data, so only DQ0 shifts in.
  always @(posedge pins_i.sclk) begin
    if (pins_i.cs_n === 1'b0 && supply_ok_i === 1'b1) begin
      cnt++;
      if (cnt <= 8) sh = {sh[6:0], pins_i.dq[0]};
      if (pins_i.dq[0] !== 1'b1 || pins_i.dq[3] !== 1'b1) allone = 1'b0;
      // The hold function stays live, so a low line 3 would stall the part.
      if (pins_i.dq[3] !== 1'b1) viol++;
    end
  end

  // The next flag bit leaves on the falling serial clock edge.
  always @(negedge pins_i.sclk) begin
    if (pins_i.cs_n === 1'b0 && sh == CMD_RD_FLAG && cnt >= 8 && cnt < 16) begin
      drv = 1'b1;
      dq1_o = (cnt == 8) ? (polls >= int'(busy_polls_i)) : (cnt == 15);
    end
  end

  // A short frame leaves nothing half decoded behind.
  always @(posedge pins_i.cs_n) begin
    t_up = $realtime;
    drv = 1'b0;
    if (cnt > 0) begin
      lens.push_back(cnt);
      cmds.push_back(sh);
      ones.push_back(allone);
    end
    if (cnt == 16 && sh == CMD_RD_FLAG) polls++;
    if (cnt == 33 && allone) xip = 1'b0;
  end

  always @(negedge pins_i.reset_n) begin
    if (pins_i.cs_n !== 1'b1) viol++;
    xip = 1'b0;
  end

  // Power-up leaves the part in standby with no command latched.
  always @(posedge supply_ok_i) begin
    cnt = 0;
    sh = 8'h00;
  end

  // A released line wanders, so a stale bit is never taken for data.
  always begin
    #5;
    if (!drv) dq1_o = ~dq1_o;
  end
endmodule

// File: xpr_seq_tb.sv
// Purpose: Self-checking bench for the flash recovery sequencer.
// Assumes: Shortened power-up counts; partner answers flag reads.
// Notes: Frame lengths and bytes are judged from the partner record.
`timescale 1ns/1ps

module xpr_seq_tb;
  // ======================================================================
  // Signals and instances
  logic clk_i;
  logic arst_n_i;
  logic supply_ok_i;
  logic wi_ok_i;
  logic flash_dq1_i;
  xpr_pkg::xpr_pins_t pins_o;
  logic start_i;
  xpr_pkg::xpr_op_t op_i;
  logic busy_o;
  logic done_o;
  logic ready_o;
  logic [7:0] status_o;
  logic [7:0] busy_polls;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  int rst_low = 0;

  xpr_seq #(.READY_CYC(2000), .WI_WAIT_CYC(50), .RST_PULSE_CYC(16)) dut (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .supply_ok_i(supply_ok_i), .wi_ok_i(wi_ok_i),
    .flash_dq1_i(flash_dq1_i), .pins_o(pins_o), .start_i(start_i), .op_i(op_i),
    .busy_o(busy_o), .done_o(done_o), .ready_o(ready_o), .status_o(status_o));

  xpr_flash_model fm (.pins_i(pins_o), .supply_ok_i(supply_ok_i),
    .busy_polls_i(busy_polls), .dq1_o(flash_dq1_i));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cyc++;
    if (pins_o.reset_n === 1'b0) rst_low++;
  end

  // ======================================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic print_verdict();
    if (fails == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic wait_ready(input logic lvl);
    int n;
    n = 0;
    while (ready_o !== lvl && n < 5000) begin
      @(posedge clk_i);
      n++;
    end
  endtask

  // A poke repeats the request mid-run; it must be ignored while busy.
  task automatic run_op(input xpr_pkg::xpr_op_t op, input bit poke, output int n);
    fm.lens.delete();
    fm.cmds.delete();
    fm.ones.delete();
    @(posedge clk_i);
    start_i <= 1'b1;
    op_i <= op;
    n = 0;
    @(posedge clk_i);
    start_i <= 1'b0;
    while (done_o !== 1'b1 && n < 20000) begin
      @(posedge clk_i);
      n++;
      start_i <= poke && n == 100;
    end
    chk("done", 1, done_o);
    chk("busy_at_done", 0, busy_o);
  endtask

  task automatic chk_series(input int tail, input int n_tail, input bit all_one);
    int exp_len[6] = '{7, 9, 13, 17, 25, 33};
    chk("frames", 6 + n_tail, fm.lens.size());
    for (int i = 0; i < fm.lens.size(); i++) begin
      chk("len", (i < 6) ? exp_len[i] : tail, fm.lens[i]);
      if (all_one || i < 6) chk("dq_high", 1, fm.ones[i]);
    end
  endtask

  // ======================================================================
  // Scenarios
  task automatic t_power_up();
    int t0;
    busy_polls = 8'h02;
    chk("rst_busy", 1, busy_o);
    chk("rst_cs", 1, pins_o.cs_n);
    chk("rst_ready", 0, ready_o);
    @(posedge clk_i);
    supply_ok_i <= 1'b1;
    wi_ok_i <= 1'b1;
    t0 = cyc;
    while (pins_o.cs_n === 1'b1 && cyc - t0 < 1000) @(posedge clk_i);
    chk("poll_wait", 1, cyc - t0 >= 50 && cyc - t0 < 64);
    wait_ready(1'b1);
    chk("ready", 1, ready_o);
    chk("polls", 3, fm.polls);
    chk("poll_cmd", 8'h70, fm.cmds[0]);
    chk("poll_len", 16, fm.lens[2]);
    chk("busy", 0, busy_o);
  endtask

  task automatic t_terminate();
    int n;
    run_op(xpr_pkg::OP_TERMINATE, 1'b1, n);
    chk_series(8, 2, 1'b0);
    chk("arm", 8'h66, fm.cmds[6]);
    chk("rst", 8'h99, fm.cmds[7]);
    chk("xip", 0, fm.xip);
    chk("oe_idle", 4'hF, pins_o.dq_oe_n);
  endtask

  task automatic t_recover_rescue();
    int n;
    run_op(xpr_pkg::OP_RECOVER, 1'b0, n);
    chk_series(8, 1, 1'b1);
    run_op(xpr_pkg::OP_RESCUE, 1'b0, n);
    chk_series(16, 1, 1'b1);
  endtask

  task automatic t_hw_reset();
    int n;
    rst_low = 0;
    run_op(xpr_pkg::OP_HW_RESET, 1'b0, n);
    // The pulse counter shares its edge with the done check, so let one edge pass.
    @(posedge clk_i);
    chk("rst_len", 16, rst_low);
    chk("rst_frames", 0, fm.lens.size());
  endtask

  task automatic t_poll_illegal();
    int n;
    busy_polls = 8'(fm.polls + 3);
    run_op(xpr_pkg::OP_POLL, 1'b0, n);
    chk("polls", 4, fm.lens.size());
    chk("status", 8'h81, status_o);
    run_op(xpr_pkg::xpr_op_t'(3'h5), 1'b0, n);
    chk("bad_op", 1, n <= 2 && fm.lens.size() == 0);
  endtask

  // The part never reports ready here, so the host must fall back on its timeout.
  task automatic t_supply_loss();
    int t0;
    busy_polls = 8'hFF;
    @(posedge clk_i);
    supply_ok_i <= 1'b0;
    wait_ready(1'b0);
    chk("ready_lost", 0, ready_o);
    repeat (100) @(posedge clk_i);
    chk("cs_idle", 1, pins_o.cs_n);
    supply_ok_i <= 1'b1;
    t0 = cyc;
    wait_ready(1'b1);
    chk("ready_back", 1, ready_o);
    chk("ready_wait", 1, cyc - t0 >= 2000);
    chk("status_busy", 8'h01, status_o);
    chk("viol", 0, fm.viol);
  endtask

  // Whole run is near 9000 cycles; a limit of 50000 leaves ample margin.
  initial begin
    #200000;
    fails++;
    print_verdict();
  end

  initial begin
    arst_n_i = 1'b0;
    supply_ok_i = 1'b0;
    wi_ok_i = 1'b0;
    start_i = 1'b0;
    op_i = xpr_pkg::OP_TERMINATE;
    busy_polls = 8'h00;
    repeat (20) @(posedge clk_i);
    arst_n_i <= 1'b1;
    t_power_up();
    t_terminate();
    t_recover_rescue();
    t_hw_reset();
    t_poll_illegal();
    t_supply_loss();
    print_verdict();
  end
endmodule
